// >>> logic/p3g_hi_latch.v
// four byte-wide output latches for ports 4 to 7
// assumes one writer per cycle; read data valid one edge after the request
`timescale 1ns/100ps
`include "p3g_regs.vh"

module p3g_hi_latch (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// write port
	input  wire        wr_en,
	input  wire [1:0]  wr_idx,
	input  wire [7:0]  wr_data,
	// registered read port
	input  wire [1:0]  rd_idx,
	output reg  [7:0]  rd_data_r,
	// all latches side by side, port 4 in the low byte
	output wire [31:0] all_latch
);

	reg [7:0] mem_r [0:3];
	integer   i;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// latches live on even without pins, so software sees them always
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 4; i = i + 1)
				mem_r[i] <= `P3G_RST_LATCH;                // [R12]
			rd_data_r <= 8'h00;
		end else begin
			if (wr_en)
				mem_r[wr_idx] <= wr_data;
			rd_data_r <= mem_r[rd_idx];
		end
	end

	// flat view for pin drive
	assign all_latch = {mem_r[3], mem_r[2], mem_r[1], mem_r[0]};

endmodule // p3g_hi_latch

// >>> logic/p3g_regs.vh
// constants for the port-3 / high-port gpio block
// assumes an 8-bit special-function register bus driven by the core
//
// Contract
// R1 - port-3 latch, bit addressable, resets to ones; 0 drives low, 1 per mode
// R2 - reading the port-3 address returns pin levels, whatever the crossbar does
// R3 - memory interface can drive all eight port-3 pins as address/data or data
// R4 - port-3 drive-mode register resets to zero; 0 open-drain, 1 push-pull
// R5 - routed i2c lines or mode-0 receive lines force their pin open-drain
// R6 - pending flags 7 and 6 set on selected edge of pins 3.7, 3.6; sticky
// R7 - edge select for interrupt 7 at bit 3: 0 falling, 1 rising
// R8 - edge select for interrupt 6 at bit 2: 0 falling, 1 rising
// R9 - flag register bits 5:4 and 1:0 read zero, ignore writes; resets zero
// R10 - ordinary reads of ports 4 to 7 return pin levels
// R11 - read-modify-write reads return latch contents instead of pin levels
// R12 - high-port latches and input paths exist even when not pinned out
// R13 - software avoids floating unpinned inputs by pull-ups, push-pull or zeros
// R14 - push-pull pin drives low for 0 and high for 1
// R15 - open-drain pin drives low for 0 and floats for 1
// R16 - each high-port mode bit sets one nibble; bit 7 is port 7 upper nibble
// R17 - software makes an input by open-drain mode and latch bit one
// R18 - pull-ups on after reset; global disable bit turns all off
// R19 - pull-up is switched off on any pin driving low
// R20 - software keeps low-port memory claim at 0 when memory uses high ports
// R21 - during external moves the memory interface overrides latch levels
// R22 - memory reads disable data-bus drivers; drive modes otherwise unchanged
// R23 - flags cleared by writing 0; edge inputs synchronised before detection
// R24 - pins 3.7 and 3.6 are the interrupt 7 and 6 edge inputs
`ifndef P3G_REGS_VH
`define P3G_REGS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define P3G_ADDR_PORT3   8'hB0
`define P3G_ADDR_P3MODE  8'hA7
`define P3G_ADDR_P3FLAG  8'hAD
`define P3G_ADDR_HIMODE  8'hB5
`define P3G_ADDR_PORT4   8'h84
`define P3G_ADDR_PORT5   8'h85
`define P3G_ADDR_PORT6   8'h86
`define P3G_ADDR_PORT7   8'h87
`define P3G_BITBASE_PORT3 5'h16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define P3G_RST_LATCH    8'hFF
`define P3G_RST_MODE     8'h00
`define P3G_RST_FLAG     8'h00

// ----------------------------------------------------------------
// flag register fields
// ----------------------------------------------------------------
`define P3G_F_IRQ7       7
`define P3G_F_IRQ6       6
`define P3G_F_SEL7       3
`define P3G_F_SEL6       2
`define P3G_F_RWMASK     8'hCC

`endif

// >>> logic/p3g_top.v
// port-3 and high-port (4..7) pin logic with two edge interrupt flags
// assumes the core's register bus, crossbar and memory interface sit
// outside and drive the override inputs synchronously to clk
`timescale 1ns/100ps
`include "p3g_regs.vh"

module p3g_top (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// register bus
	input  wire [7:0]  sfr_addr,
	input  wire        sfr_wr,
	input  wire [7:0]  sfr_wdata,
	input  wire        sfr_rd,
	input  wire        sfr_rmw,
	input  wire        sfr_bit_wr,
	input  wire [7:0]  sfr_bit_addr,
	input  wire        sfr_bit_val,
	output reg  [7:0]  sfr_rdata_r,
	output reg         sfr_rvalid_r,
	// global controls from the crossbar
	input  wire        pullup_global_off,
	input  wire [7:0]  port3_force_od,
	input  wire [7:0]  port3_periph_sel,
	input  wire [7:0]  port3_periph_dat,
	// memory interface on port 3
	input  wire        xmem_port3_active,
	input  wire [7:0]  xmem_port3_dat,
	input  wire        xmem_port3_rd,
	// memory interface on the high ports
	input  wire [31:0] xmem_hi_own,
	input  wire [31:0] xmem_hi_dat,
	input  wire [31:0] xmem_hi_rd_off,
	// port-3 pins
	input  wire [7:0]  port3_pin_in,
	output reg  [7:0]  port3_pin_out_r,
	output reg  [7:0]  port3_pin_oe_n_r,
	output reg  [7:0]  port3_pullup_en_r,
	// high-port pins, port 4 in the low byte
	input  wire [31:0] hi_pin_in,
	output reg  [31:0] hi_pin_out_r,
	output reg  [31:0] hi_pin_oe_n_r,
	output reg  [31:0] hi_pullup_en_r,
	// edge flags toward the interrupt controller
	output reg         ext_irq7_pending_r,
	output reg         ext_irq6_pending_r
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// low-active enable: driven for a 0, or for a 1 in push-pull
	function drv_oe_n;
		input d;
		input pp;
		begin
			drv_oe_n = ~(~d | pp);                             // [R14] [R15]
		end
	endfunction

	// pull-up only when allowed and the pin is not pulling low
	function pu_en;
		input d;
		input oe_n;
		input off;
		begin
			pu_en = ~off & ~(~d & ~oe_n);                      // [R18] [R19]
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [7:0] port3_latch_r;
	reg [7:0] port3_latch_nxt;
	reg [7:0] port3_drive_mode_r;
	reg [7:0] high_ports_nibble_drive_mode_r;
	reg       ext_irq7_edge_sel_r;
	reg       ext_irq6_edge_sel_r;
	reg [1:0] edge_s1_r;
	reg [1:0] edge_s2_r;
	reg [1:0] edge_s3_r;
	reg       rd_q_r;
	reg       rmw_q_r;
	reg [7:0] addr_q_r;
	reg       irq7_nxt;
	reg       irq6_nxt;
	reg [7:0] rdata_nxt;

	wire        hi_sel;
	wire        hi_wr;
	wire [7:0]  hi_rd_data;
	wire [31:0] hi_latch;
	wire        rise7;
	wire        fall7;
	wire        rise6;
	wire        fall6;
	wire        hit7;
	wire        hit6;
	wire        wr_flag;

	// ----------------------------------------------------------------
	// high-port latches
	// ----------------------------------------------------------------
	assign hi_sel = ((sfr_addr & 8'hFC) == `P3G_ADDR_PORT4);
	assign hi_wr  = sfr_wr & hi_sel;

	p3g_hi_latch u_hi_latch (
		.clk       (clk),
		.rst       (rst),
		.wr_en     (hi_wr),
		.wr_idx    (sfr_addr[1:0]),
		.wr_data   (sfr_wdata),
		.rd_idx    (sfr_addr[1:0]),
		.rd_data_r (hi_rd_data),
		.all_latch (hi_latch)
	);

	// ----------------------------------------------------------------
	// port-3 latch, byte and bit writes
	// ----------------------------------------------------------------
	always @* begin
		port3_latch_nxt = port3_latch_r;
		if (sfr_wr && sfr_addr == `P3G_ADDR_PORT3)
			port3_latch_nxt = sfr_wdata;                      // [R1]
		if (sfr_bit_wr && sfr_bit_addr[7:3] == `P3G_BITBASE_PORT3)
			port3_latch_nxt[sfr_bit_addr[2:0]] = sfr_bit_val; // [R1]
	end

	// configuration registers
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			port3_latch_r                  <= `P3G_RST_LATCH;
			port3_drive_mode_r             <= `P3G_RST_MODE;  // [R4]
			high_ports_nibble_drive_mode_r <= `P3G_RST_MODE;
		end else begin
			port3_latch_r <= port3_latch_nxt;
			if (sfr_wr && sfr_addr == `P3G_ADDR_P3MODE)
				port3_drive_mode_r <= sfr_wdata;              // [R4]
			if (sfr_wr && sfr_addr == `P3G_ADDR_HIMODE)
				high_ports_nibble_drive_mode_r <= sfr_wdata;  // [R16]
		end
	end

	// ----------------------------------------------------------------
	// edge detection on pins 3.7 and 3.6
	// ----------------------------------------------------------------
	// two-stage sync, then a third stage only the detectors read
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			edge_s1_r <= 2'h3;
			edge_s2_r <= 2'h3;
			edge_s3_r <= 2'h3;
		end else begin
			edge_s1_r <= port3_pin_in[7:6];                   // [R24] [R23]
			edge_s2_r <= edge_s1_r;
			edge_s3_r <= edge_s2_r;
		end
	end

	assign rise7 = edge_s2_r[1] & ~edge_s3_r[1];
	assign fall7 = ~edge_s2_r[1] & edge_s3_r[1];
	assign rise6 = edge_s2_r[0] & ~edge_s3_r[0];
	assign fall6 = ~edge_s2_r[0] & edge_s3_r[0];
	assign hit7  = ext_irq7_edge_sel_r ? rise7 : fall7;      // [R7]
	assign hit6  = ext_irq6_edge_sel_r ? rise6 : fall6;      // [R8]

	// ----------------------------------------------------------------
	// pending flags: a detected edge beats a same-cycle clear
	// ----------------------------------------------------------------
	assign wr_flag = sfr_wr & (sfr_addr == `P3G_ADDR_P3FLAG);

	always @* begin
		irq7_nxt = ext_irq7_pending_r;
		irq6_nxt = ext_irq6_pending_r;
		if (wr_flag) begin
			irq7_nxt = sfr_wdata[`P3G_F_IRQ7];                // [R23]
			irq6_nxt = sfr_wdata[`P3G_F_IRQ6];
		end
		if (hit7)
			irq7_nxt = 1'b1;                                  // [R6]
		if (hit6)
			irq6_nxt = 1'b1;                                  // [R6]
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_irq7_pending_r  <= 1'b0;                      // [R9]
			ext_irq6_pending_r  <= 1'b0;
			ext_irq7_edge_sel_r <= 1'b0;
			ext_irq6_edge_sel_r <= 1'b0;
		end else begin
			ext_irq7_pending_r <= irq7_nxt;
			ext_irq6_pending_r <= irq6_nxt;
			if (wr_flag) begin
				ext_irq7_edge_sel_r <= sfr_wdata[`P3G_F_SEL7]; // [R7]
				ext_irq6_edge_sel_r <= sfr_wdata[`P3G_F_SEL6]; // [R8]
			end
		end
	end

	// ----------------------------------------------------------------
	// register reads, answered two edges after the request
	// ----------------------------------------------------------------
	// the extra stage lets the latch memory's registered port catch up
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_q_r   <= 1'b0;
			rmw_q_r  <= 1'b0;
			addr_q_r <= 8'h00;
		end else begin
			rd_q_r   <= sfr_rd;
			rmw_q_r  <= sfr_rmw;
			addr_q_r <= sfr_addr;
		end
	end

	always @* begin
		rdata_nxt = 8'h00;
		case (addr_q_r)
			`P3G_ADDR_PORT3:
				rdata_nxt = rmw_q_r ? port3_latch_r : port3_pin_in; // [R2] [R11]
			`P3G_ADDR_P3MODE:
				rdata_nxt = port3_drive_mode_r;
			`P3G_ADDR_P3FLAG:
				rdata_nxt = {ext_irq7_pending_r, ext_irq6_pending_r, 2'b00,
				             ext_irq7_edge_sel_r, ext_irq6_edge_sel_r,
				             2'b00};                          // [R9]
			`P3G_ADDR_HIMODE:
				rdata_nxt = high_ports_nibble_drive_mode_r;
			`P3G_ADDR_PORT4, `P3G_ADDR_PORT5, `P3G_ADDR_PORT6, `P3G_ADDR_PORT7:
				rdata_nxt = rmw_q_r ? hi_rd_data
				          : hi_pin_in[addr_q_r[1:0]*8 +: 8];  // [R10] [R11]
			default:
				rdata_nxt = 8'h00;
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sfr_rdata_r  <= 8'h00;
			sfr_rvalid_r <= 1'b0;
		end else begin
			sfr_rvalid_r <= rd_q_r;
			if (rd_q_r)
				sfr_rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// port-3 pin drive
	// ----------------------------------------------------------------
	reg [7:0]  port3_d;
	reg [7:0]  port3_oe_n;
	reg [7:0]  port3_pu;
	integer    k;

	// memory interface first, then the crossbar, then the latch
	always @* begin
		port3_d    = 8'h00;
		port3_oe_n = 8'hFF;
		port3_pu   = 8'h00;
		for (k = 0; k < 8; k = k + 1) begin
			if (xmem_port3_active)
				port3_d[k] = xmem_port3_dat[k];               // [R3]
			else if (port3_periph_sel[k])
				port3_d[k] = port3_periph_dat[k];
			else
				port3_d[k] = port3_latch_r[k];                // [R1]
			port3_oe_n[k] = drv_oe_n(port3_d[k],
			                port3_drive_mode_r[k] & ~port3_force_od[k]); // [R1] [R5]
			if (xmem_port3_active && xmem_port3_rd)
				port3_oe_n[k] = 1'b1;                         // [R22]
			port3_pu[k] = pu_en(port3_d[k], port3_oe_n[k], pullup_global_off);
		end
	end

	// ----------------------------------------------------------------
	// high-port pin drive, one mode bit per nibble
	// ----------------------------------------------------------------
	reg [31:0] hi_d;
	reg [31:0] hi_oe_n;
	reg [31:0] hi_pu;
	integer    n;

	always @* begin
		hi_d    = 32'h00000000;
		hi_oe_n = 32'hFFFFFFFF;
		hi_pu   = 32'h00000000;
		for (n = 0; n < 32; n = n + 1) begin
			hi_d[n] = xmem_hi_own[n] ? xmem_hi_dat[n] : hi_latch[n]; // [R21]
			hi_oe_n[n] = drv_oe_n(hi_d[n],
			             high_ports_nibble_drive_mode_r[n/4]);       // [R16]
			if (xmem_hi_own[n] && xmem_hi_rd_off[n])
				hi_oe_n[n] = 1'b1;                            // [R22]
			hi_pu[n] = pu_en(hi_d[n], hi_oe_n[n], pullup_global_off);
		end
	end

	// pins come straight from flops; reset leaves all released, pulled up
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			port3_pin_out_r   <= 8'hFF;
			port3_pin_oe_n_r  <= 8'hFF;
			port3_pullup_en_r <= 8'hFF;                       // [R18]
			hi_pin_out_r   <= 32'hFFFFFFFF;
			hi_pin_oe_n_r  <= 32'hFFFFFFFF;
			hi_pullup_en_r <= 32'hFFFFFFFF;                   // [R18]
		end else begin
			port3_pin_out_r   <= port3_d;
			port3_pin_oe_n_r  <= port3_oe_n;
			port3_pullup_en_r <= port3_pu;
			hi_pin_out_r   <= hi_d;
			hi_pin_oe_n_r  <= hi_oe_n;
			hi_pullup_en_r <= hi_pu;
		end
	end

endmodule // p3g_top

// >>> verification/p3g_board.sv
// board circuitry on all 40 pins, port 3 in the low byte
// assumes the pins are weakly pulled up only by the device itself
`timescale 1ns/100ps
module p3g_board (
	// clock for the floating-line pattern
	input logic         clk,
	// device side
	input logic [39:0]  out,
	input logic [39:0]  oe_n,
	input logic [39:0]  pu,
	// board switches pulling pins low
	input logic [39:0]  ext_low,
	output logic [39:0] pin
);
	logic flt_r = 1'b0;
	// a line nobody holds wanders instead of keeping its last level
	always @(posedge clk) flt_r <= ~flt_r;
	always_comb
		for (int i = 0; i < 40; i++)
			pin[i] = !oe_n[i] ? out[i] : ext_low[i] ? 1'b0 : pu[i] ? 1'b1 : flt_r;
endmodule // p3g_board

// >>> verification/p3g_props_properties.sv
// assertions on port-3 pin drive, register reads and the edge flags
// assumes it is bound onto p3g_top and sees only that module's ports
`timescale 1ns/100ps
module p3g_props (
	// clock and reset
	input logic        clk,
	input logic        rst,
	// register bus
	input logic [7:0]  sfr_addr,
	input logic        sfr_wr,
	input logic [7:0]  sfr_wdata,
	input logic        sfr_rd,
	input logic        sfr_bit_wr,
	input logic [7:0]  sfr_rdata_r,
	input logic        sfr_rvalid_r,
	// controls and pins
	input logic        pullup_global_off,
	input logic [7:0]  port3_force_od,
	input logic [7:0]  port3_periph_sel,
	input logic        xmem_port3_active,
	input logic [7:0]  xmem_port3_dat,
	input logic        xmem_port3_rd,
	input logic [7:0]  port3_pin_in,
	input logic [7:0]  port3_pin_out_r,
	input logic [7:0]  port3_pin_oe_n_r,
	input logic [7:0]  port3_pullup_en_r,
	input logic [31:0] hi_pullup_en_r,
	input logic        ext_irq7_pending_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic sel7_r;
	// shadow of the edge select, since the flag register is hidden from here
	always @(posedge clk or posedge rst) begin
		if (rst)
			sel7_r <= 1'b0;
		else if (sfr_wr && sfr_addr == 8'hAD)
			sel7_r <= sfr_wdata[3];
	end
	property p_rd_lat; sfr_rd |-> ##2 sfr_rvalid_r; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_unused;
		sfr_rvalid_r && $past(sfr_rd, 2) && $past(sfr_addr, 2) == 8'hAD
			|-> (sfr_rdata_r & 8'h33) == 8'h00;
	endproperty
	a_unused: assert property (p_unused) else $error("unused flag bits set");
	property p_pu_low;
		(port3_pullup_en_r & ~port3_pin_oe_n_r & ~port3_pin_out_r) == 8'h00;
	endproperty
	a_pu_low: assert property (p_pu_low) else $error("pull-up on a low pin");
	property p_pu_off;
		$past(pullup_global_off) |-> port3_pullup_en_r == 8'h00 && hi_pullup_en_r == 32'h0;
	endproperty
	a_pu_off: assert property (p_pu_off) else $error("pull-up not disabled");
	property p_force;
		$past(port3_force_od) == 8'hFF && !$past(xmem_port3_active)
			|-> (~port3_pin_oe_n_r & port3_pin_out_r) == 8'h00;
	endproperty
	a_force: assert property (p_force) else $error("forced pin driven high");
	property p_sticky;
		$fell(ext_irq7_pending_r) |-> $past(sfr_wr && sfr_addr == 8'hAD && !sfr_wdata[7]);
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag cleared by itself");
	property p_edge7;
		port3_pin_in[7] != $past(port3_pin_in[7]) && port3_pin_in[7] == sel7_r
			|-> ##[1:5] ext_irq7_pending_r;
	endproperty
	a_edge7: assert property (p_edge7) else $error("edge missed");
	property p_latch0;
		(sfr_wr && !sfr_bit_wr && sfr_addr == 8'hB0 && sfr_wdata == 8'h00)
			##1 (!xmem_port3_active && port3_periph_sel == 8'h00 && !sfr_wr && !sfr_bit_wr)
			|-> ##1 port3_pin_out_r == 8'h00 && port3_pin_oe_n_r == 8'h00;
	endproperty
	a_latch0: assert property (p_latch0) else $error("zero latch not driven");
	property p_xrd;
		$past(xmem_port3_active && xmem_port3_rd) |-> port3_pin_oe_n_r == 8'hFF;
	endproperty
	a_xrd: assert property (p_xrd) else $error("drivers on in read");
	property p_xdat;
		$past(xmem_port3_active && !xmem_port3_rd) |-> port3_pin_out_r == $past(xmem_port3_dat);
	endproperty
	a_xdat: assert property (p_xdat) else $error("memory byte not on pins");
	c_flag: cover property ($rose(ext_irq7_pending_r));
	c_xrd: cover property (xmem_port3_active && xmem_port3_rd);
	c_rd: cover property (sfr_rvalid_r);
endmodule // p3g_props
bind p3g_top p3g_props u_props (.clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
	.sfr_bit_wr, .sfr_rdata_r, .sfr_rvalid_r, .pullup_global_off, .port3_force_od,
	.port3_periph_sel, .xmem_port3_active, .xmem_port3_dat, .xmem_port3_rd, .port3_pin_in,
	.port3_pin_out_r, .port3_pin_oe_n_r, .port3_pullup_en_r, .hi_pullup_en_r,
	.ext_irq7_pending_r);

// >>> verification/p3g_top_bench.sv
// self-checking bench for p3g_top with a board model on the pins
// assumes inputs change on the falling edge only
`timescale 1ns/100ps
`include "p3g_regs.vh"
module p3g_top_bench;
	logic        clk, rst, sfr_wr, sfr_rd, sfr_rmw, sfr_bit_wr, sfr_bit_val;
	logic        pullup_global_off, xmem_port3_active, xmem_port3_rd;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_bit_addr, port3_force_od, xmem_port3_dat;
	logic [31:0] xmem_hi_own, xmem_hi_dat;
	logic [39:0] ext_low;
	wire  [7:0]  sfr_rdata_r, port3_pin_in, port3_pin_out_r, port3_pin_oe_n_r;
	wire  [7:0]  port3_pullup_en_r;
	wire         sfr_rvalid_r, ext_irq7_pending_r, ext_irq6_pending_r;
	wire  [31:0] hi_pin_in, hi_pin_out_r, hi_pin_oe_n_r, hi_pullup_en_r;
	int          mismatches, compares, cycles;
	// crossbar peripheral and high-port read-off paths are tied off
	p3g_top dut (.clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rmw, .sfr_bit_wr,
		.sfr_bit_addr, .sfr_bit_val, .sfr_rdata_r, .sfr_rvalid_r, .pullup_global_off,
		.port3_force_od, .port3_periph_sel(8'h00), .port3_periph_dat(8'h00),
		.xmem_port3_active, .xmem_port3_dat, .xmem_port3_rd, .xmem_hi_own, .xmem_hi_dat,
		.xmem_hi_rd_off(32'h0), .port3_pin_in, .port3_pin_out_r, .port3_pin_oe_n_r,
		.port3_pullup_en_r, .hi_pin_in, .hi_pin_out_r, .hi_pin_oe_n_r, .hi_pullup_en_r,
		.ext_irq7_pending_r, .ext_irq6_pending_r);
	p3g_board board (.clk, .out({hi_pin_out_r, port3_pin_out_r}),
		.oe_n({hi_pin_oe_n_r, port3_pin_oe_n_r}), .pu({hi_pullup_en_r, port3_pullup_en_r}),
		.ext_low, .pin({hi_pin_in, port3_pin_in}));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// run ceiling, far above the roughly 190 cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			results;
		end
	end
	task results;
		$display("comparisons %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [39:0] got, input logic [39:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask
	// read is taken at one edge, answer pulses two edges later
	task rd(input logic [7:0] a, input logic m, input logic [7:0] exp);
		int n;
		@(negedge clk);
		sfr_addr = a;
		sfr_rmw = m;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		n = 0;
		while (sfr_rvalid_r !== 1'b1 && n < 4) begin
			@(negedge clk);
			n++;
		end
		chk(sfr_rvalid_r, 1'b1);
		chk(sfr_rdata_r, exp);
	endtask
	task settle;
		repeat (6) @(negedge clk);
	endtask
	task t_reset;
		rd(`P3G_ADDR_PORT3, 1'b1, 8'hFF);
		rd(`P3G_ADDR_P3MODE, 1'b0, 8'h00);
		rd(`P3G_ADDR_P3FLAG, 1'b0, 8'h00);
		chk(port3_pin_oe_n_r, 8'hFF);
		chk(port3_pullup_en_r, 8'hFF);
	endtask
	task t_drive;
		wr(`P3G_ADDR_P3MODE, 8'h0F);
		wr(`P3G_ADDR_PORT3, 8'hDA);
		settle;
		chk(port3_pin_out_r, 8'hDA);
		chk(port3_pin_oe_n_r, 8'hD0);
		chk(port3_pullup_en_r, 8'hDA);
		ext_low[7] = 1'b1;
		settle;
		rd(`P3G_ADDR_PORT3, 1'b0, 8'h5A);
		rd(`P3G_ADDR_PORT3, 1'b1, 8'hDA);
		rd(`P3G_ADDR_P3FLAG, 1'b0, 8'h80);
		@(negedge clk);
		sfr_bit_addr = 8'hB0;
		sfr_bit_val = 1'b1;
		sfr_bit_wr = 1'b1;
		@(negedge clk);
		sfr_bit_wr = 1'b0;
		rd(`P3G_ADDR_PORT3, 1'b1, 8'hDB);
	endtask
	task t_edge;
		for (int s = 0; s < 2; s++) begin
			// park the pins at the level opposite to the wanted edge first
			ext_low[7:6] = s ? 2'b11 : 2'b00;
			settle;
			wr(`P3G_ADDR_P3FLAG, s ? 8'h0C : 8'h00);
			rd(`P3G_ADDR_P3FLAG, 1'b0, s ? 8'h0C : 8'h00);
			ext_low[7:6] = s ? 2'b00 : 2'b11;
			settle;
			chk({ext_irq7_pending_r, ext_irq6_pending_r}, 2'b11);
			rd(`P3G_ADDR_P3FLAG, 1'b0, s ? 8'hCC : 8'hC0);
		end
		ext_low[7:6] = 2'b11;
		settle;
		wr(`P3G_ADDR_P3FLAG, 8'hFF);
		rd(`P3G_ADDR_P3FLAG, 1'b0, 8'hCC);
		wr(`P3G_ADDR_P3FLAG, 8'h00);
		ext_low[7:6] = 2'b00;
		settle;
		rd(`P3G_ADDR_P3FLAG, 1'b0, 8'h00);
	endtask
	task t_force;
		port3_force_od = 8'hFF;
		wr(`P3G_ADDR_P3MODE, 8'hFF);
		wr(`P3G_ADDR_PORT3, 8'hAA);
		settle;
		chk(port3_pin_oe_n_r, 8'hAA);
		port3_force_od = 8'h00;
		settle;
		chk(port3_pin_oe_n_r, 8'h00);
		wr(`P3G_ADDR_PORT3, 8'h00);
		settle;
		chk(port3_pin_out_r, 8'h00);
	endtask
	task t_xmem;
		xmem_port3_dat = 8'h3C;
		xmem_port3_active = 1'b1;
		settle;
		chk(port3_pin_out_r, 8'h3C);
		chk(port3_pin_oe_n_r, 8'h00);
		xmem_port3_rd = 1'b1;
		settle;
		chk(port3_pin_oe_n_r, 8'hFF);
		xmem_port3_rd = 1'b0;
		xmem_port3_active = 1'b0;
	endtask
	task t_high;
		wr(`P3G_ADDR_HIMODE, 8'h80);
		wr(`P3G_ADDR_PORT7, 8'hA5);
		settle;
		chk(hi_pin_out_r[31:24], 8'hA5);
		chk(hi_pin_oe_n_r[31:24], 8'h05);
		ext_low[32] = 1'b1;
		settle;
		rd(`P3G_ADDR_PORT7, 1'b0, 8'hA4);
		rd(`P3G_ADDR_PORT7, 1'b1, 8'hA5);
		wr(`P3G_ADDR_PORT4, 8'h00);
		settle;
		chk(hi_pin_oe_n_r[7:0], 8'h00);
		// low-port memory claim xmem_port3_active was cleared in t_xmem, so it stays off
		xmem_hi_own = 32'h1;
		xmem_hi_dat = 32'h1;
		settle;
		chk(hi_pin_out_r[0], 1'b1);
		xmem_hi_own = 32'h0;
		rd(8'h90, 1'b0, 8'h00);
	endtask
	// last, because unpulled pins then float
	task t_pullup;
		pullup_global_off = 1'b1;
		settle;
		chk({hi_pullup_en_r, port3_pullup_en_r}, 40'h0);
	endtask
	initial begin
		{sfr_wr, sfr_rd, sfr_rmw, sfr_bit_wr, sfr_bit_val, pullup_global_off} = 6'h00;
		{sfr_addr, sfr_wdata, sfr_bit_addr, port3_force_od, xmem_port3_dat} = 40'h0;
		{xmem_port3_active, xmem_port3_rd, xmem_hi_own, xmem_hi_dat, ext_low} = 106'h0;
		rst = 1'b1;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		t_reset;
		t_drive;
		t_edge;
		t_force;
		t_xmem;
		t_high;
		t_pullup;
		results;
	end
endmodule // p3g_top_bench
